/* File: src/sac_pkg.sv */
// constants shared by the secondary converter control block
package sac_pkg;
    // special function register addresses
    localparam logic [7:0] ADDR_PAIR_CFG = 8'hBA;
    localparam logic [7:0] ADDR_CHAN_SEL = 8'hBB;
    localparam logic [7:0] ADDR_CFG      = 8'hBC;
    localparam logic [7:0] ADDR_DATA     = 8'hBE;
    localparam logic [7:0] ADDR_CTRL     = 8'hE8;
    // reset values
    localparam logic [7:0] RST_PAIR_CFG  = 8'h00;
    localparam logic [7:0] RST_CHAN_SEL  = 8'h00;
    localparam logic [7:0] RST_CFG       = 8'hF8;
    localparam logic [7:0] RST_CTRL      = 8'h00;
    localparam logic [7:0] RST_DATA      = 8'h00;
    // writable masks; unused bits read zero
    localparam logic [7:0] MASK_PAIR_CFG = 8'h0F;
    localparam logic [7:0] MASK_CHAN_SEL = 8'h07;
    localparam logic [7:0] MASK_CFG      = 8'hFB;
    // field positions
    localparam int CFG_DIV_LSB  = 3;
    localparam int CFG_GAIN_LSB = 0;
    localparam int CTRL_EN      = 7;
    localparam int CTRL_TM      = 6;
    localparam int CTRL_DONE    = 5;
    localparam int CTRL_BUSY    = 4;
    localparam int CTRL_CM_LSB  = 1;
    localparam int CTRL_WINT    = 0;
    // start source codes
    localparam logic [2:0] CM_SOFT   = 3'h0;
    localparam logic [2:0] CM_TMR3   = 3'h1;
    localparam logic [2:0] CM_STROBE = 3'h2;
    localparam logic [2:0] CM_TMR2   = 3'h3;
    // gain codes
    localparam logic [1:0] GAIN_HALF = 2'h0;
    localparam logic [1:0] GAIN_ONE  = 2'h1;
    localparam logic [1:0] GAIN_TWO  = 2'h2;
    localparam logic [1:0] GAIN_FOUR = 2'h3;
    // timing
    localparam int SYS_CLK_HZ     = 25000000;
    localparam int SAR_MAX_HZ     = 6000000;
    localparam int TRACK_SAR_CLKS = 3;
    localparam int SETTLE_NS      = 800;
    localparam int SETTLE_CYC     = (SETTLE_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
    localparam int CONV_SAR_CLKS  = 8;
    typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_CONV} sac_state_t;
endpackage

/* File: src/sac_conv_ctrl.sv */
// conversion control for the secondary 8-bit successive-approximation converter
// Summary of operation
// - eight analog inputs; channel address field picks the one measured
// - gain choices 0.5, 1, 2, 4; gain is 0.5 after reset
// - conversion clock is system clock divided; software keeps it at most 6 MHz
// - five start sources chosen by three-bit start source select
// - software source: writing one to busy bit starts; zero does nothing
// - timer 3 or timer 2 overflow starts a conversion when selected
// - external strobe source: rising strobe edge starts a conversion
// - shared source: primary converter busy write starts this converter too
// - busy bit reads one throughout a conversion, zero when finished
// - falling busy edge sets done flag and raises enabled interrupt
// - each finished conversion places its result in the data word
// - normal track mode tracks continuously except while converting
// - low-power mode: start gives three conversion clocks tracking, then conversion
// - low-power with strobe source: track while strobe low, convert on rise
// - tracking can be switched off while the chip is in standby or sleep
// - each pair bit makes even/odd pair differential when one
// - results two's complement for differential, unsigned for single-ended
// - address picks input per pair setup; either member selects the pair
// - unused upper bits of pair and channel registers read zero
// - start codes 000 soft, 001 timer 3, 010 strobe, 011 timer 2, 1xx primary
// - divisor is five bits; conversion clock is system clock over divisor plus one
// - gain code 00 0.5, 01 1, 10 2, 11 4
`timescale 1ns/1ns
module sac_conv_ctrl #(
    parameter int CONV_CLKS  = sac_pkg::CONV_SAR_CLKS,  // conversion clocks per result
    parameter int TRACK_CLKS = sac_pkg::TRACK_SAR_CLKS  // low-power tracking clocks
) (
    input  wire logic       clk_sys,       // system clock, 25 MHz
    input  wire logic       rst,           // asynchronous reset, active high
    input  wire logic [7:0] sfrAddr,       // register address
    input  wire logic       sfrWrEn,       // register write strobe
    input  wire logic [7:0] sfrWrData,     // register write data
    input  wire logic       timer3Ovf,     // timer 3 overflow pulse
    input  wire logic       timer2Ovf,     // timer 2 overflow pulse
    input  wire logic       extStrobePin,  // external convert strobe pin
    input  wire logic       primaryBusyWr, // one written to primary busy bit
    input  wire logic       standby,       // chip in standby or sleep
    input  wire logic       irqEnable,     // interrupt enable from the core
    input  wire logic [7:0] anaResult,     // raw offset-binary code from the array
    output logic      [7:0] sfrRdData,     // read data, one cycle after address
    output logic            convIrq,       // interrupt request level
    output logic            trackEn,       // track-and-hold in track
    output logic            convBusy,      // conversion in progress
    output logic            sarTick,       // one pulse per conversion clock
    output logic      [2:0] anaPos,        // channel address to the multiplexer
    output logic            anaDiff,       // selected input is a differential pair
    output logic      [1:0] anaGain,       // amplifier gain code
    output logic            anaEnable      // converter subsystem powered
);
    import sac_pkg::*;

    // an odd address inside a differential pair measures the same pair, so
    // only the upper two address bits pick the configuration bit
    // true when the selected address falls in a pair marked differential
    function automatic logic pairDiff(input logic [7:0] pc, input logic [2:0] ad);
        pairDiff = pc[ad[2:1]];
    endfunction

    logic [7:0] pairCfg_reg,  pairCfg_next;
    logic [7:0] chanSel_reg,  chanSel_next;
    logic [7:0] cfg_reg,      cfg_next;
    logic [7:0] ctrl_reg,     ctrl_next;
    logic [7:0] data_reg,     data_next;
    logic [7:0] rdData_reg,   rdData_next;
    logic       irq_reg,      irq_next;
    logic       diff_reg,     diff_next;
    logic [2:0] sync_reg;
    logic       stbLvl_reg,   stbLvl_next;
    logic [4:0] divCnt_reg,   divCnt_next;
    logic       tick_reg,     tick_next;
    logic [7:0] cnt_reg,      cnt_next;
    logic       track_reg,    track_next;
    logic       busy_reg,     busy_next;
    sac_state_t state_reg,    state_next;

    // helpers decoded from the current register contents
    logic [2:0] srcSel;
    logic [4:0] divisor;
    logic       enabled;
    logic       lowPower;
    logic       stbRise;
    logic       swStart;
    logic       startEv;
    logic       finish;
    logic       tickNow;

    assign srcSel   = ctrl_reg[CTRL_CM_LSB +: 3];
    assign divisor  = cfg_reg[CFG_DIV_LSB +: 5];
    assign enabled  = ctrl_reg[CTRL_EN];
    assign lowPower = ctrl_reg[CTRL_TM];
    assign tickNow  = (divCnt_reg >= divisor);

    // the pin may change at any moment, so the first stage can go metastable;
    // only the later stages feed the level filter, and a glitch shorter than
    // one clock never reaches the edge detector
    // strobe synchroniser; a level change counts once stages two and three agree
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync_reg <= 3'h0;
        end else begin
            sync_reg <= {sync_reg[1:0], extStrobePin};
        end
    end

    always_comb begin
        stbLvl_next = stbLvl_reg;
        if (sync_reg[1] == sync_reg[2]) begin
            stbLvl_next = sync_reg[2];
        end
    end

    assign stbRise = stbLvl_next & ~stbLvl_reg;

    // the timers and the primary converter's start run on this clock and
    // arrive as one-cycle pulses, so they need no synchroniser
    // start event decode; a write of zero to busy never starts anything
    assign swStart = sfrWrEn && (sfrAddr == ADDR_CTRL)
                  && sfrWrData[CTRL_BUSY] && (srcSel == CM_SOFT);

    always_comb begin
        unique case (srcSel)
            CM_SOFT:   startEv = swStart;
            CM_TMR3:   startEv = timer3Ovf;
            CM_STROBE: startEv = stbRise;
            CM_TMR2:   startEv = timer2Ovf;
            default:   startEv = primaryBusyWr;
        endcase
    end

    // limitation: the divider is not restarted by a start event, so the first
    // counted conversion clock of a sequence may be short; realigning it
    // would cost a reload path for little gain
    // conversion clock divider: free running, wraps at the divisor
    always_comb begin
        divCnt_next = tickNow ? 5'h00 : divCnt_reg + 5'h01;
        tick_next   = tickNow;
    end

    // the counter is shared by the tracking and converting phases; it is
    // cleared on entry to each so that both phases count from zero
    // sequencer: track, convert, finish
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        finish     = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                // starts while busy never reach here, so they are dropped
                if (startEv && enabled) begin
                    cnt_next = 8'h00;
                    if (lowPower && srcSel != CM_STROBE) begin
                        state_next = ST_TRACK;
                    end else begin
                        // with the strobe in low-power mode its low phase was
                        // the tracking period, so a rise converts at once
                        state_next = ST_CONV;
                    end
                end
            end
            ST_TRACK: begin
                if (tickNow) begin
                    cnt_next = cnt_reg + 8'h01;
                    if (cnt_reg == 8'(TRACK_CLKS - 1)) begin
                        cnt_next   = 8'h00;
                        state_next = ST_CONV;
                    end
                end
            end
            ST_CONV: begin
                if (tickNow) begin
                    cnt_next = cnt_reg + 8'h01;
                    if (cnt_reg == 8'(CONV_CLKS - 1)) begin
                        finish     = 1'b1;
                        state_next = ST_IDLE;
                    end
                end
            end
        endcase
        // disabling the converter abandons a conversion, but one whose last clock falls in the first disabled cycle still stores its result
        if (!enabled) begin
            state_next = ST_IDLE;
        end
    end

    // busy is registered from the next state so that it rises in the cycle
    // the sequencer leaves idle, matching the read-back busy bit
    // track-and-hold steering
    always_comb begin
        busy_next = (state_next != ST_IDLE);
        if (!enabled || standby) begin
            track_next = 1'b0;
        end else if (!lowPower) begin
            track_next = (state_next == ST_IDLE);
        end else if (srcSel == CM_STROBE) begin
            track_next = (state_next == ST_IDLE) && !stbLvl_next;
        end else begin
            track_next = (state_next == ST_TRACK);
        end
    end

    // the busy bit is never stored: a write of one is only a start request,
    // and reads take the bit from the sequencer instead
    // the window flag, bit zero, is plain storage here because the window
    // comparator lives outside this block
    // register file writes; hardware set of the done flag wins over a clear
    always_comb begin
        pairCfg_next = pairCfg_reg;
        chanSel_next = chanSel_reg;
        cfg_next     = cfg_reg;
        ctrl_next    = ctrl_reg;
        data_next    = data_reg;
        if (sfrWrEn) begin
            unique case (sfrAddr)
                ADDR_PAIR_CFG: pairCfg_next = sfrWrData & MASK_PAIR_CFG;
                ADDR_CHAN_SEL: chanSel_next = sfrWrData & MASK_CHAN_SEL;
                ADDR_CFG:      cfg_next = sfrWrData & MASK_CFG;
                ADDR_CTRL:     ctrl_next = sfrWrData & ~(8'h01 << CTRL_BUSY);
                default:       ;
            endcase
        end
        if (finish) begin
            // differential codes flip the top bit to give two's complement
            data_next = anaResult ^ {diff_reg, 7'h00};
            ctrl_next[CTRL_DONE] = 1'b1;
        end
        diff_next = pairDiff(pairCfg_next, chanSel_next[2:0]);
        irq_next  = ctrl_next[CTRL_DONE] && irqEnable;
    end

    // reads have no side effects, so the core may poll the control register
    // as often as it likes while waiting for the done flag
    // read port: data lands one cycle after the address
    always_comb begin
        unique case (sfrAddr)
            ADDR_PAIR_CFG: rdData_next = pairCfg_reg;
            ADDR_CHAN_SEL: rdData_next = chanSel_reg;
            ADDR_CFG:      rdData_next = cfg_reg;
            ADDR_DATA:     rdData_next = data_reg;
            ADDR_CTRL: begin
                rdData_next = ctrl_reg;
                rdData_next[CTRL_BUSY] = (state_reg != ST_IDLE);
            end
            default:       rdData_next = 8'h00;
        endcase
    end

    // all state registers except the strobe synchroniser
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pairCfg_reg <= RST_PAIR_CFG;
            chanSel_reg <= RST_CHAN_SEL;
            cfg_reg     <= RST_CFG;
            ctrl_reg    <= RST_CTRL;
            data_reg    <= RST_DATA;
            rdData_reg  <= 8'h00;
            irq_reg     <= 1'b0;
            diff_reg    <= 1'b0;
            stbLvl_reg  <= 1'b0;
            divCnt_reg  <= 5'h00;
            tick_reg    <= 1'b0;
            cnt_reg     <= 8'h00;
            track_reg   <= 1'b0;
            busy_reg    <= 1'b0;
            state_reg   <= ST_IDLE;
        end else begin
            pairCfg_reg <= pairCfg_next;
            chanSel_reg <= chanSel_next;
            cfg_reg     <= cfg_next;
            ctrl_reg    <= ctrl_next;
            data_reg    <= data_next;
            rdData_reg  <= rdData_next;
            irq_reg     <= irq_next;
            diff_reg    <= diff_next;
            stbLvl_reg  <= stbLvl_next;
            divCnt_reg  <= divCnt_next;
            tick_reg    <= tick_next;
            cnt_reg     <= cnt_next;
            track_reg   <= track_next;
            busy_reg    <= busy_next;
            state_reg   <= state_next;
        end
    end

    // busy has its own flop rather than a decode of the state, so the
    // analog side sees no glitch while the state changes
    // outputs straight from flip-flops
    assign sfrRdData = rdData_reg;
    assign convIrq   = irq_reg;
    assign trackEn   = track_reg;
    assign convBusy  = busy_reg;
    assign sarTick   = tick_reg;
    assign anaPos    = chanSel_reg[2:0];
    assign anaDiff   = diff_reg;
    assign anaGain   = cfg_reg[CFG_GAIN_LSB +: 2];
    assign anaEnable = ctrl_reg[CTRL_EN];
endmodule

/* File: verification/sac_conv_ctrl_props.sv */
// concurrent checks on the converter control ports
`timescale 1ns/1ns
module sac_conv_ctrl_props
    import sac_pkg::*;
#(
    parameter int CONV_CLKS  = 8,
    parameter int TRACK_CLKS = 3
) (
    input wire logic       clk_sys,       // clock
    input wire logic       rst,           // reset
    input wire logic [7:0] sfrAddr,       // address
    input wire logic       sfrWrEn,       // write strobe
    input wire logic [7:0] sfrWrData,     // write data
    input wire logic       timer3Ovf,     // timer 3
    input wire logic       timer2Ovf,     // timer 2
    input wire logic       primaryBusyWr, // shared start
    input wire logic       irqEnable,     // irq enable
    input wire logic [7:0] sfrRdData,     // read data
    input wire logic       convIrq,       // irq
    input wire logic       trackEn,       // tracking
    input wire logic       convBusy,      // busy
    input wire logic       sarTick,       // conv clock
    input wire logic [1:0] anaGain        // gain
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [7:0] ctrlReg, ctrlNext;
    logic [4:0] divReg, divNext;
    logic [1:0] gainReg, gainNext;
    logic [5:0] gapReg, gapNext;
    logic       okReg, okNext, wrCtl, wrCfg, mapped, startEv;
    // write decode and the start event that the selected source should give, strobe source excluded
    assign wrCtl = sfrWrEn && sfrAddr == ADDR_CTRL;
    assign wrCfg = sfrWrEn && sfrAddr == ADDR_CFG;
    assign mapped = sfrAddr inside {ADDR_PAIR_CFG, ADDR_CHAN_SEL, ADDR_CFG, ADDR_DATA, ADDR_CTRL};
    assign startEv = ctrlReg[7] && ((wrCtl && sfrWrData[4] && ctrlReg[3:1] == CM_SOFT)
        || (ctrlReg[3:1] == CM_TMR3 && timer3Ovf) || (ctrlReg[3:1] == CM_TMR2 && timer2Ovf)
        || (ctrlReg[3] && primaryBusyWr));
    // tick spacing is judged only over an interval with no divisor write
    always_comb begin
        ctrlNext = wrCtl ? sfrWrData : ctrlReg;
        {divNext, gainNext} = wrCfg ? {sfrWrData[7:3], sfrWrData[1:0]} : {divReg, gainReg};
        gapNext = sarTick ? 6'h00 : gapReg + 6'h01;
        okNext = (sarTick || okReg) && !wrCfg;
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {ctrlReg, divReg, gainReg, gapReg, okReg} <= {RST_CTRL, 5'h1F, 8'h00, 1'b0};
        end else begin
            {ctrlReg, divReg, gainReg, gapReg, okReg} <= {ctrlNext, divNext, gainNext, gapNext,
                okNext};
        end
    end
    sequence s_lp_track;
        trackEn [*2] ##[0:2] (convBusy && !trackEn);
    endsequence
    a_unmapped_reads_zero: assert property (!mapped |=> sfrRdData == 8'h00)
        else $error("unmapped read not zero");
    a_gain_follows: assert property (wrCfg |=> anaGain == gainReg)
        else $error("gain output differs from written code");
    a_done_raises_irq: assert property ($fell(convBusy) && irqEnable |=> convIrq)
        else $error("no interrupt after conversion end");
    a_source_starts: assert property (startEv && !convBusy
        && !(wrCtl && !sfrWrData[7]) |=> convBusy)
        else $error("selected start source did not start");
    a_no_stray_start: assert property (!convBusy && !startEv && !wrCtl
        && ctrlReg[3:1] != CM_STROBE |=> !convBusy) else $error("start from other source");
    a_conv_no_track: assert property (convBusy && !ctrlReg[6] |-> !trackEn)
        else $error("tracking during conversion");
    a_lp_track_first: assert property ($rose(convBusy) && ctrlReg[6]
        && ctrlReg[3:1] != CM_STROBE && divReg == 5'h00 |-> ##[0:1] s_lp_track)
        else $error("low-power tracking period wrong");
    a_tick_gap: assert property (sarTick && okReg |-> gapReg == {1'b0, divReg})
        else $error("conversion clock spacing wrong");
endmodule
bind sac_conv_ctrl sac_conv_ctrl_props #(.CONV_CLKS(CONV_CLKS), .TRACK_CLKS(TRACK_CLKS))
    sac_conv_ctrl_props_i (.clk_sys, .rst, .sfrAddr, .sfrWrEn, .sfrWrData, .timer3Ovf,
    .timer2Ovf, .primaryBusyWr, .irqEnable, .sfrRdData, .convIrq, .trackEn, .convBusy,
    .sarTick, .anaGain);

/* File: verification/sac_analog_src.sv */
// analog array and timer overflow model facing the converter control
`timescale 1ns/1ns
module sac_analog_src #(
    parameter int T3_PER = 37, // timer 3 period
    parameter int T2_PER = 53  // timer 2 period
) (
    input  wire logic       clk_sys,   // clock
    input  wire logic       rst,       // reset
    input  wire logic [2:0] anaPos,    // selected input
    output logic      [7:0] anaResult, // raw code
    output logic            timer3Ovf, // timer 3 overflow
    output logic            timer2Ovf  // timer 2 overflow
);
    int c3, c2;
    // each input shows its address in the top bits, so a wrong mux choice is seen
    assign anaResult = {anaPos, 5'h0B};
    // free-running timers with unequal periods so a wrong source shows
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {c3, c2, timer3Ovf, timer2Ovf} <= '0;
        end else begin
            c3 <= (c3 == T3_PER - 1) ? 0 : c3 + 1;
            c2 <= (c2 == T2_PER - 1) ? 0 : c2 + 1;
            timer3Ovf <= c3 == T3_PER - 1;
            timer2Ovf <= c2 == T2_PER - 1;
        end
    end
endmodule

/* File: verification/sac_conv_ctrl_tb_top.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ns
module sac_conv_ctrl_tb_top;
    import sac_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} sac_row_t;
    logic       clk_sys, rst, sfrWrEn, extStrobePin, primaryBusyWr, standby, irqEnable;
    logic       timer3Ovf, timer2Ovf, convIrq, trackEn, convBusy, sarTick, anaDiff, anaEnable;
    logic [7:0] sfrAddr, sfrWrData, anaResult, sfrRdData, rv;
    logic [2:0] anaPos, ch;
    logic [1:0] anaGain;
    int         fails = 0, total_checks = 0;
    // rows: address, value written, value read back
    sac_row_t   rows [6] = '{'{ADDR_PAIR_CFG, 8'hFF, 8'h0F}, '{ADDR_CHAN_SEL, 8'hFF, 8'h07},
        '{ADDR_CFG, 8'hFF, 8'hFB}, '{ADDR_DATA, 8'h5A, 8'h00}, '{8'hC0, 8'h12, 8'h00},
        '{ADDR_CFG, 8'h03, 8'h03}};
    logic [2:0] srcs [5] = '{CM_TMR3, CM_STROBE, CM_TMR2, 3'h4, 3'h7};
    logic [7:0] rstA [5] = '{ADDR_PAIR_CFG, ADDR_CHAN_SEL, ADDR_CFG, ADDR_DATA, ADDR_CTRL};
    logic [7:0] rstE [5] = '{RST_PAIR_CFG, RST_CHAN_SEL, RST_CFG, RST_DATA, RST_CTRL};
    sac_conv_ctrl sac_conv_ctrl_i (.clk_sys, .rst, .sfrAddr, .sfrWrEn, .sfrWrData, .timer3Ovf,
        .timer2Ovf, .extStrobePin, .primaryBusyWr, .standby, .irqEnable, .anaResult, .sfrRdData,
        .convIrq, .trackEn, .convBusy, .sarTick, .anaPos, .anaDiff, .anaGain, .anaEnable);
    sac_analog_src sac_analog_src_i (.clk_sys, .rst, .anaPos, .anaResult, .timer3Ovf, .timer2Ovf);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // one write cycle; returns just after the write edge so outputs have settled
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys) {sfrAddr, sfrWrData, sfrWrEn} <= {a, d, 1'b1};
        @(posedge clk_sys) sfrWrEn <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys) sfrAddr <= a;
        @(posedge clk_sys) #1 d = sfrRdData;
    endtask
    // bounded wait for one whole conversion, then fetch the data word
    task automatic conv(output logic [7:0] res);
        int n;
        n = 0;
        while (convBusy !== 1'b1 && n < 300) @(posedge clk_sys) #1 n++;
        while (convBusy !== 1'b0 && n < 300) @(posedge clk_sys) #1 n++;
        chk({7'h00, n < 300}, 8'h01);
        rd(ADDR_DATA, res);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // watchdog well beyond the expected run of under 700 cycles
    initial begin
        repeat (6000) @(posedge clk_sys);
        fails++;
        report_and_stop();
    end
    initial begin
        {rst, sfrWrEn, extStrobePin, primaryBusyWr, standby, irqEnable} = 6'b100001;
        {sfrAddr, sfrWrData} = 16'h0000;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rv);
            chk(rv, rows[i].e);
        end
        // pairs 0 and 2 differential; every address, even and odd members
        wr(ADDR_PAIR_CFG, 8'h05);
        for (int i = 0; i < 8; i++) begin
            ch = 3'(i);
            wr(ADDR_CHAN_SEL, {5'h00, ch});
            repeat (SETTLE_CYC) @(posedge clk_sys);
            #1 chk({4'h0, anaDiff, anaPos}, {4'h0, ~ch[1], ch});
            wr(ADDR_CTRL, 8'h80);
            wr(ADDR_CTRL, 8'h90);
            conv(rv);
            chk(rv, {ch[2] ^ ~ch[1], ch[1:0], 5'h0B});
            rd(ADDR_CTRL, rv);
            chk(rv, 8'hA0);
            chk({7'h00, convIrq}, 8'h01);
        end
        wr(ADDR_CTRL, 8'hA0);
        repeat (3) @(posedge clk_sys);
        #1 chk({7'h00, convBusy}, 8'h00);
        rd(ADDR_CTRL, rv);
        chk(rv, 8'hA0);
        // every other start source in turn, channel 7 single-ended
        foreach (srcs[i]) begin
            wr(ADDR_CTRL, {4'h8, srcs[i], 1'b0});
            @(posedge clk_sys) {extStrobePin, primaryBusyWr} <= {srcs[i] == CM_STROBE, srcs[i][2]};
            @(posedge clk_sys) primaryBusyWr <= 1'b0;
            conv(rv);
            chk(rv, 8'hEB);
            @(posedge clk_sys) extStrobePin <= 1'b0;
        end
        wr(ADDR_CTRL, 8'hC0);
        repeat (2) @(posedge clk_sys);
        #1 chk({7'h00, trackEn}, 8'h00);
        wr(ADDR_CTRL, 8'hD0);
        conv(rv);
        chk(rv, 8'hEB);
        wr(ADDR_CTRL, 8'hC4);
        repeat (6) @(posedge clk_sys);
        #1 chk({7'h00, trackEn}, 8'h01);
        @(posedge clk_sys) extStrobePin <= 1'b1;
        conv(rv);
        chk({7'h00, trackEn}, 8'h00);
        @(posedge clk_sys) extStrobePin <= 1'b0;
        repeat (6) @(posedge clk_sys);
        wr(ADDR_CTRL, 8'h80);
        repeat (2) @(posedge clk_sys);
        #1 chk({7'h00, trackEn}, 8'h01);
        chk({7'h00, anaEnable}, 8'h01);
        @(posedge clk_sys) standby <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 chk({7'h00, trackEn}, 8'h00);
        // second reset in mid-run, then the default divisor is left running
        @(posedge clk_sys) rst <= 1'b1;
        @(posedge clk_sys) rst <= 1'b0;
        #1 chk({6'h00, anaGain}, 8'h00);
        chk({7'h00, anaEnable}, 8'h00);
        foreach (rstA[i]) begin
            rd(rstA[i], rv);
            chk(rv, rstE[i]);
        end
        repeat (80) @(posedge clk_sys);
        report_and_stop();
    end
endmodule
